// ===== dv/oct_host_model.sv
// ==========================================
// Host side of the register port
module oct_host_model (
	input  wire logic             ref_clk,
	output oct_pkg::oct_reg_req_t req,
	input  wire logic [15:0]      rdata,
	input  wire logic             rvalid
);
	timeunit 1ns;
	timeprecision 100ps;

	initial req = '0;

	// Released bus shows inverted junk, never the last value
	task automatic idle();
		req.wr    = 1'b0;
		req.rd    = 1'b0;
		req.addr  = ~req.addr;
		req.wdata = ~req.wdata;
	endtask : idle

	// One write strobe, taken at the next edge
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		#1;
		req.addr  = a;
		req.wdata = d;
		req.wr    = 1'b1;
		@(posedge ref_clk);
		#1;
		idle();
	endtask : wr

	// Read answer is registered at the taking edge and sampled just after it
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		#1;
		req.addr = a;
		req.rd   = 1'b1;
		@(posedge ref_clk);
		#1;
		idle();
		d = (rvalid === 1'b1) ? rdata : 16'hxxxx;
	endtask : rd
endmodule : oct_host_model

// ===== dv/osc_calibration_timestamp_test.sv
`include "oct_params.svh"

module osc_calibration_timestamp_test;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================
	// Signals
	logic                    ref_clk = 1'b0;
	logic                    nrst = 1'b0;
	logic                    hf_tick = 1'b0;
	logic                    lf_tick = 1'b0;
	logic                    lf_src_is_32k = 1'b0;
	logic                    general_pin_zero = 1'b0;
	logic                    stamp_alt_pin = 1'b0;
	logic                    stamp_use_alt = 1'b0;
	oct_pkg::oct_stamp_src_t stamp_src = '0;
	oct_pkg::oct_stamp_src_t m_src = '0;
	oct_pkg::oct_reg_req_t   reg_req;
	logic [15:0]             reg_rdata_r;
	logic                    reg_rvalid_r;
	logic [7:0]              fast_trim;
	logic [9:0]              low_trim;
	logic [5:0]              slow_trim;
	logic                    gate;
	logic                    busy;
	logic                    m_run = 1'b0;
	logic [15:0]             v;
	logic [15:0]             d;
	int                      bad_count = 0;
	int                      samples_checked = 0;
	int                      hfc, lfc, lfn, m_tally, tick_n;
	logic [15:0] addrs [7] = '{`OCT_ADDR_FAST_TRIM, `OCT_ADDR_FAST_CAL, `OCT_ADDR_LOW_TRIM,
		`OCT_ADDR_SLOW_TRIM, `OCT_ADDR_STAMP_LOW, `OCT_ADDR_STAMP_HIGH, `OCT_ADDR_SLOT_REMAIN};
	logic [15:0] rstv [7] = '{16'h0090, 16'h0000, 16'h02b2, 16'h0012, 16'h0000, 16'h0000, 16'h0000};

	always #5 ref_clk = ~ref_clk;

	oct_top dut (.ref_clk(ref_clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r),
		.reg_rvalid_r(reg_rvalid_r), .hf_tick(hf_tick), .lf_tick(lf_tick),
		.lf_src_is_32k(lf_src_is_32k), .general_pin_zero(general_pin_zero),
		.stamp_alt_pin(stamp_alt_pin), .stamp_use_alt(stamp_use_alt), .stamp_src(stamp_src),
		.fast_osc_trim_code_r(fast_trim), .low_osc_trim_code_r(low_trim),
		.slow_osc_trim_code_r(slow_trim), .calibration_clock_gate_r(gate),
		.calibration_busy_r(busy));

	oct_host_model host (.ref_clk(ref_clk), .req(reg_req), .rdata(reg_rdata_r),
		.rvalid(reg_rvalid_r));

	// Oscillator ticks: random fast, every third cycle slow
	always @(posedge ref_clk) begin
		#1;
		hf_tick = 1'($urandom_range(0, 1));
		tick_n++;
		lf_tick = (tick_n % 3 == 0);
	end

	// Reference tally: counting from the edge after the start
	always @(posedge ref_clk) begin
		if (m_run) begin
			hfc += hf_tick;
			lfc += lf_tick;
			if (lfc == lfn) begin
				m_tally = hfc;
				m_run   = 1'b0;
			end
		end
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// Wrong pin rises first with stale source, then the selected one
	task automatic cap(input logic alt, input logic arm);
		oct_pkg::oct_stamp_src_t src;
		src = {$urandom, 16'($urandom)};
		if (arm)
			host.wr(`OCT_ADDR_SLOW_TRIM, 16'h8012);
		stamp_use_alt = alt;
		if (alt) general_pin_zero = 1'b1;
		else stamp_alt_pin = 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		stamp_src = src;
		if (arm) m_src = src;
		if (alt) stamp_alt_pin = 1'b1;
		else general_pin_zero = 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		general_pin_zero = 1'b0;
		stamp_alt_pin    = 1'b0;
		host.rd(`OCT_ADDR_STAMP_LOW, v);
		chk("stamp_low", v, m_src.stamp_count[15:0]);
		host.rd(`OCT_ADDR_STAMP_HIGH, v);
		chk("stamp_high", v, m_src.stamp_count[31:16]);
		host.rd(`OCT_ADDR_SLOT_REMAIN, v);
		chk("slot", v, m_src.slot_remaining);
		host.rd(`OCT_ADDR_SLOW_TRIM, v);
		chk("arm_clear", v, 16'h0012);
	endtask : cap

	// Hang guard, far above the several hundred cycles needed
	initial begin
		#100000;
		bad_count++;
		test_done();
	end

	initial begin
		void'($urandom(32'hb7a4));
		repeat (2) @(posedge ref_clk);
		#1;
		nrst = 1'b1;
		// Reset values
		for (int i = 0; i < 7; i++) begin
			host.rd(addrs[i], v);
			chk("reset", v, rstv[i]);
		end
		// Trims at both extremes and random; reserved bits read zero
		for (int i = 0; i < 5; i++) begin
			d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
			host.wr(`OCT_ADDR_FAST_TRIM, d);
			host.rd(`OCT_ADDR_FAST_TRIM, v);
			chk("fast", {v, 8'h00, fast_trim}, {8'h00, d[7:0], 8'h00, d[7:0]});
			host.wr(`OCT_ADDR_LOW_TRIM, d & 16'hfbff);
			host.rd(`OCT_ADDR_LOW_TRIM, v);
			chk("low", {v, 6'h00, low_trim}, {6'h00, d[9:0], 6'h00, d[9:0]});
			host.wr(`OCT_ADDR_SLOW_TRIM, d & 16'h7fff);
			host.rd(`OCT_ADDR_SLOW_TRIM, v);
			chk("slow", {v, 10'h000, slow_trim}, {10'h000, d[5:0], 10'h000, d[5:0]});
		end
		// Read-only and unmapped places
		host.wr(`OCT_ADDR_STAMP_LOW, 16'hffff);
		host.rd(`OCT_ADDR_STAMP_LOW, v);
		chk("ro_write", v, 16'h0000);
		host.rd(16'h0010, v);
		chk("unmapped", v, 16'h0000);
		// Start refused while the gate is closed
		host.wr(`OCT_ADDR_FAST_CAL, 16'h8000);
		host.rd(`OCT_ADDR_FAST_CAL, v);
		chk("go_gated", {v, busy}, 17'h00000);
		// software opens the gate before calibrating
		host.wr(`OCT_ADDR_LOW_TRIM, 16'h06b2);
		chk("gate", gate, 1'b1);
		for (int s = 0; s < 2; s++) begin
			lf_src_is_32k = 1'(s);
			lfn = s ? 32 : 128;
			host.wr(`OCT_ADDR_FAST_CAL, 16'h8000);
			hfc   = 0;
			lfc   = 0;
			m_run = 1'b1;
			chk("busy", busy, 1'b1);
			for (int n = 0; n < 400; n++) begin
				host.rd(`OCT_ADDR_FAST_CAL, v);
				if (v[15] === 1'b0)
					break;
			end
			chk("go_clear", {v[15], busy, m_run}, 3'b000);
			chk("tally", v[14:0], m_tally[14:0]);
		end
		// closing the gate mid-run aborts, last tally kept
		host.wr(`OCT_ADDR_FAST_CAL, 16'h8000);
		host.wr(`OCT_ADDR_LOW_TRIM, 16'h02b2);
		host.rd(`OCT_ADDR_FAST_CAL, v);
		chk("abort", {v, busy}, {1'b0, m_tally[14:0], 1'b0});
		cap(1'b0, 1'b1);
		cap(1'b0, 1'b0);
		cap(1'b1, 1'b1);
		test_done();
	end
endmodule : osc_calibration_timestamp_test

// ===== hw/oct_params.svh
`ifndef OCT_PARAMS_SVH
`define OCT_PARAMS_SVH

// ==========================================
// Register offsets
`define OCT_ADDR_FAST_TRIM   16'h0009
`define OCT_ADDR_FAST_CAL    16'h000a
`define OCT_ADDR_LOW_TRIM    16'h000b
`define OCT_ADDR_SLOW_TRIM   16'h000c
`define OCT_ADDR_STAMP_LOW   16'h0011
`define OCT_ADDR_STAMP_HIGH  16'h0012
`define OCT_ADDR_SLOT_REMAIN 16'h0013

// ==========================================
// Field positions
`define OCT_CAL_GO_BIT       15
`define OCT_CAL_GATE_BIT     10
`define OCT_CAPTURE_ARM_BIT  15

// ==========================================
// Reset values
`define OCT_FAST_TRIM_RST    8'h90
`define OCT_LOW_TRIM_RST     10'h2b2
`define OCT_SLOW_TRIM_RST    6'h12

// ==========================================
// Calibration windows in low-frequency cycles
`define OCT_WIN_1M           8'h80
`define OCT_WIN_32K          8'h20

`endif

// ===== hw/oct_pkg.sv
package oct_pkg;

	// ==========================================
	// Register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} oct_reg_req_t;

	// Inputs sampled at a time-stamp capture
	typedef struct packed {
		logic [31:0] stamp_count;
		logic [15:0] slot_remaining;
	} oct_stamp_src_t;

	// Calibration sequencer states
	typedef enum logic {
		OCT_CAL_IDLE,
		OCT_CAL_RUN
	} oct_cal_state_t;

endpackage : oct_pkg

// ===== hw/oct_top.sv
`include "oct_params.svh"

module oct_top (
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	input  wire oct_pkg::oct_reg_req_t   reg_req,
	output logic        [15:0]           reg_rdata_r,
	output logic                         reg_rvalid_r,
	input  wire logic                    hf_tick,
	input  wire logic                    lf_tick,
	input  wire logic                    lf_src_is_32k,
	input  wire logic                    general_pin_zero,
	input  wire logic                    stamp_alt_pin,
	input  wire logic                    stamp_use_alt,
	input  wire oct_pkg::oct_stamp_src_t stamp_src,
	output logic        [7:0]            fast_osc_trim_code_r,
	output logic        [9:0]            low_osc_trim_code_r,
	output logic        [5:0]            slow_osc_trim_code_r,
	output logic                         calibration_clock_gate_r,
	output logic                         calibration_busy_r
);

	// ==========================================
	// Declarations
	logic                    wr_fast;
	logic                    wr_cal;
	logic                    wr_low;
	logic                    wr_slow;
	logic [7:0]              fast_trim_nxt;
	logic [9:0]              low_trim_nxt;
	logic [5:0]              slow_trim_nxt;
	logic                    gate_nxt;
	oct_pkg::oct_cal_state_t cal_state_r;
	oct_pkg::oct_cal_state_t cal_state_nxt;
	logic                    cal_go_r;
	logic                    cal_go_nxt;
	logic [14:0]             hf_count_r;
	logic [14:0]             hf_count_nxt;
	logic [7:0]              lf_count_r;
	logic [7:0]              lf_count_nxt;
	logic [7:0]              window_r;
	logic [7:0]              window_nxt;
	logic [14:0]             calibration_tally_r;
	logic [14:0]             tally_nxt;
	logic                    cal_done;
	logic                    busy_nxt;
	logic                    stamp_pin;
	logic                    sync1_r;
	logic                    sync2_r;
	logic                    sync3_r;
	logic                    stamp_rise;
	logic                    capture_arm_r;
	logic                    arm_nxt;
	logic                    capture_now;
	logic [15:0]             captured_count_low_r;
	logic [15:0]             captured_count_high_r;
	logic [15:0]             slot_remaining_value_r;
	logic [15:0]             cnt_low_nxt;
	logic [15:0]             cnt_high_nxt;
	logic [15:0]             slot_nxt;
	logic [15:0]             rdata_nxt;

	// Address match on a write strobe, used for every writable register
	function automatic logic wr_hit(input oct_pkg::oct_reg_req_t req, input logic [15:0] a);
		wr_hit = req.wr && (req.addr == a);
	endfunction : wr_hit

	assign wr_fast = wr_hit(reg_req, `OCT_ADDR_FAST_TRIM);
	assign wr_cal  = wr_hit(reg_req, `OCT_ADDR_FAST_CAL);
	assign wr_low  = wr_hit(reg_req, `OCT_ADDR_LOW_TRIM);
	assign wr_slow = wr_hit(reg_req, `OCT_ADDR_SLOW_TRIM);

	// ==========================================
	// Trim and enable registers
	always_comb begin
		fast_trim_nxt = fast_osc_trim_code_r;
		low_trim_nxt  = low_osc_trim_code_r;
		slow_trim_nxt = slow_osc_trim_code_r;
		gate_nxt      = calibration_clock_gate_r;
		if (wr_fast) begin
			fast_trim_nxt = reg_req.wdata[7:0];
		end
		if (wr_low) begin
			low_trim_nxt = reg_req.wdata[9:0];
			gate_nxt     = reg_req.wdata[`OCT_CAL_GATE_BIT];
		end
		// slow trim write, code sense inverted downstream
		if (wr_slow) begin
			slow_trim_nxt = reg_req.wdata[5:0];
		end
	end

	// Trim reset values give the nominal oscillator rates
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fast_osc_trim_code_r     <= `OCT_FAST_TRIM_RST;
			low_osc_trim_code_r      <= `OCT_LOW_TRIM_RST;
			slow_osc_trim_code_r     <= `OCT_SLOW_TRIM_RST;
			calibration_clock_gate_r <= 1'b0;
		end else begin
			fast_osc_trim_code_r     <= fast_trim_nxt;
			low_osc_trim_code_r      <= low_trim_nxt;
			slow_osc_trim_code_r     <= slow_trim_nxt;
			calibration_clock_gate_r <= gate_nxt;
		end
	end

	// ==========================================
	// Calibration sequencer
	assign cal_done = (cal_state_r == oct_pkg::OCT_CAL_RUN) && lf_tick
		&& (lf_count_r == window_r - 8'h01);

	always_comb begin
		cal_state_nxt = cal_state_r;
		cal_go_nxt    = cal_go_r;
		hf_count_nxt  = hf_count_r;
		lf_count_nxt  = lf_count_r;
		window_nxt    = window_r;
		tally_nxt     = calibration_tally_r;
		case (cal_state_r)
			oct_pkg::OCT_CAL_IDLE: begin
				// start on go write, only with gate on
				if (wr_cal && reg_req.wdata[`OCT_CAL_GO_BIT] && calibration_clock_gate_r) begin
					cal_state_nxt = oct_pkg::OCT_CAL_RUN;
					cal_go_nxt    = 1'b1;
					hf_count_nxt  = 15'h0000;
					lf_count_nxt  = 8'h00;
					window_nxt    = lf_src_is_32k ? `OCT_WIN_32K : `OCT_WIN_1M;
				end
			end
			oct_pkg::OCT_CAL_RUN: begin
				// Saturate rather than wrap so a fast clock reads as maximum
				if (hf_tick && hf_count_r != 15'h7fff) begin
					hf_count_nxt = hf_count_r + 15'h0001;
				end
				if (lf_tick) begin
					lf_count_nxt = lf_count_r + 8'h01;
				end
				// gate dropped mid-run aborts, tally kept
				if (!calibration_clock_gate_r) begin
					cal_state_nxt = oct_pkg::OCT_CAL_IDLE;
					cal_go_nxt    = 1'b0;
				end else if (cal_done) begin
					// tally takes count including this edge
					tally_nxt     = hf_count_nxt;
					cal_go_nxt    = 1'b0;
					cal_state_nxt = oct_pkg::OCT_CAL_IDLE;
				end
			end
			default: begin
				cal_state_nxt = oct_pkg::OCT_CAL_IDLE;
				cal_go_nxt    = 1'b0;
			end
		endcase
	end

	assign busy_nxt = cal_go_nxt;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cal_state_r         <= oct_pkg::OCT_CAL_IDLE;
			cal_go_r            <= 1'b0;
			hf_count_r          <= 15'h0000;
			lf_count_r          <= 8'h00;
			window_r            <= `OCT_WIN_1M;
			calibration_tally_r <= 15'h0000;
			calibration_busy_r  <= 1'b0;
		end else begin
			cal_state_r         <= cal_state_nxt;
			cal_go_r            <= cal_go_nxt;
			hf_count_r          <= hf_count_nxt;
			lf_count_r          <= lf_count_nxt;
			window_r            <= window_nxt;
			calibration_tally_r <= tally_nxt;
			calibration_busy_r  <= busy_nxt;
		end
	end

	// ==========================================
	// Time-stamp capture
	// pin zero unless routed elsewhere
	assign stamp_pin   = stamp_use_alt ? stamp_alt_pin : general_pin_zero;
	// edge taken from second and third stages only
	assign stamp_rise  = sync2_r && !sync3_r;
	assign capture_now = capture_arm_r && stamp_rise;

	always_comb begin
		arm_nxt      = capture_arm_r;
		cnt_low_nxt  = captured_count_low_r;
		cnt_high_nxt = captured_count_high_r;
		slot_nxt     = slot_remaining_value_r;
		if (capture_now) begin
			arm_nxt = 1'b0;
		end
		// A write in the capture cycle wins, so a re-arm is never lost
		if (wr_slow) begin
			arm_nxt = reg_req.wdata[`OCT_CAPTURE_ARM_BIT];
		end
		// both values from the same edge
		if (capture_now) begin
			cnt_low_nxt  = stamp_src.stamp_count[15:0];
			cnt_high_nxt = stamp_src.stamp_count[31:16];
			slot_nxt     = stamp_src.slot_remaining;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_r                <= 1'b0;
			sync2_r                <= 1'b0;
			sync3_r                <= 1'b0;
			capture_arm_r          <= 1'b0;
			captured_count_low_r   <= 16'h0000;
			captured_count_high_r  <= 16'h0000;
			slot_remaining_value_r <= 16'h0000;
		end else begin
			sync1_r                <= stamp_pin;
			sync2_r                <= sync1_r;
			sync3_r                <= sync2_r;
			capture_arm_r          <= arm_nxt;
			captured_count_low_r   <= cnt_low_nxt;
			captured_count_high_r  <= cnt_high_nxt;
			slot_remaining_value_r <= slot_nxt;
		end
	end

	// ==========================================
	// Read port, one cycle latency, unmapped reads zero
	always_comb begin
		rdata_nxt = 16'h0000;
		if (reg_req.rd) begin
			case (reg_req.addr)
				`OCT_ADDR_FAST_TRIM:   rdata_nxt = {8'h00, fast_osc_trim_code_r};
				`OCT_ADDR_FAST_CAL:    rdata_nxt = {cal_go_r, calibration_tally_r};
				`OCT_ADDR_LOW_TRIM:    rdata_nxt = {5'h00, calibration_clock_gate_r,
					low_osc_trim_code_r};
				`OCT_ADDR_SLOW_TRIM:   rdata_nxt = {capture_arm_r, 9'h000, slow_osc_trim_code_r};
				`OCT_ADDR_STAMP_LOW:   rdata_nxt = captured_count_low_r;
				`OCT_ADDR_STAMP_HIGH:  rdata_nxt = captured_count_high_r;
				`OCT_ADDR_SLOT_REMAIN: rdata_nxt = slot_remaining_value_r;
				default:               rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_r  <= 16'h0000;
			reg_rvalid_r <= 1'b0;
		end else begin
			reg_rdata_r  <= rdata_nxt;
			reg_rvalid_r <= reg_req.rd;
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	property p_fast_trim;
		wr_fast |=> fast_osc_trim_code_r == $past(reg_req.wdata[7:0]);
	endproperty
	a_fast_trim: assert property (p_fast_trim) else $error("fast trim not loaded");

	property p_go_start;
		(cal_state_r == oct_pkg::OCT_CAL_IDLE) && wr_cal && reg_req.wdata[15]
			&& calibration_clock_gate_r |=> cal_go_r && hf_count_r == 15'h0000;
	endproperty
	a_go_start: assert property (p_go_start) else $error("calibration did not start");

	property p_window;
		cal_state_r == oct_pkg::OCT_CAL_RUN |-> lf_count_r < window_r
			&& (window_r == 8'h80 || window_r == 8'h20);
	endproperty
	a_window: assert property (p_window) else $error("window overrun");

	property p_tally;
		cal_done && calibration_clock_gate_r |=> !cal_go_r
			&& calibration_tally_r == $past(hf_count_nxt);
	endproperty
	a_tally: assert property (p_tally) else $error("tally or go wrong at end");

	property p_go_falls;
		$fell(cal_go_r) |-> $past(cal_done) || !$past(calibration_clock_gate_r);
	endproperty
	a_go_falls: assert property (p_go_falls) else $error("go cleared without cause");

	property p_gate_off;
		!calibration_clock_gate_r |=> cal_state_r == oct_pkg::OCT_CAL_IDLE;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("calibration ran with gate off");

	property p_low_trim;
		wr_low |=> low_osc_trim_code_r == $past(reg_req.wdata[9:0])
			&& calibration_clock_gate_r == $past(reg_req.wdata[10]);
	endproperty
	a_low_trim: assert property (p_low_trim) else $error("low trim not loaded");

	property p_capture_edge;
		capture_now |-> $past(general_pin_zero, 3) == 1'b0 || stamp_use_alt
			|| $past(stamp_use_alt, 3);
	endproperty
	a_capture_edge: assert property (p_capture_edge) else $error("capture without edge");

	property p_disarm;
		capture_now && !wr_slow |=> !capture_arm_r;
	endproperty
	a_disarm: assert property (p_disarm) else $error("arm not cleared");

	property p_slow_trim;
		wr_slow |=> slow_osc_trim_code_r == $past(reg_req.wdata[5:0]);
	endproperty
	a_slow_trim: assert property (p_slow_trim) else $error("slow trim not loaded");

	property p_same_edge;
		capture_now |=> captured_count_high_r == $past(stamp_src.stamp_count[31:16])
			&& captured_count_low_r == $past(stamp_src.stamp_count[15:0])
			&& slot_remaining_value_r == $past(stamp_src.slot_remaining);
	endproperty
	a_same_edge: assert property (p_same_edge) else $error("capture values mismatched");

	property p_hold;
		!capture_now |=> $stable(captured_count_low_r) && $stable(slot_remaining_value_r)
			&& $stable(captured_count_high_r);
	endproperty
	a_hold: assert property (p_hold) else $error("captured value changed");

endmodule : oct_top
